// [rtl/pin_xbar_consts.vh]
// register offsets, field positions and reset values for the pin crossbar
`ifndef PIN_XBAR_CONSTS_VH
`define PIN_XBAR_CONSTS_VH
`define XBAR_ADDR_W        8
`define ADDR_ROUTE_A       8'hE1
`define ADDR_ROUTE_B       8'hE2
`define ADDR_INPUT_KIND0   8'hF1
`define ADDR_DRIVE_KIND0   8'hA4
`define ADDR_BYPASS0       8'hD4
`define ADDR_INPUT_KIND1   8'hF2
`define ADDR_DRIVE_KIND1   8'hA5
`define ADDR_BYPASS1       8'hD5
`define ADDR_INPUT_KIND2   8'hF3
`define ADDR_DRIVE_KIND2   8'hA6
`define ADDR_BYPASS2       8'hD6
`define ADDR_LATCH0        8'h80
`define ADDR_LATCH1        8'h90
`define ADDR_LATCH2        8'hA0
`define RST_ROUTE          8'h00
`define RST_INPUT_KIND     8'hFF
`define RST_DRIVE_KIND     8'h00
`define RST_BYPASS         8'h00
`define RST_LATCH          8'hFF
`define RA_UART            0
`define RA_SPI             1
`define RA_SMBUS           2
`define RA_INVERTED_SYSTEM_CLOCK_OUT          3
`define RA_CP0             4
`define RA_CP0A            5
`define RA_CP1             6
`define RA_CP1A            7
`define RB_CEX_LO          0
`define RB_CEX_HI          2
`define RB_ECI             3
`define RB_T0              4
`define RB_T1              5
`define RB_XBAR_ON         6
`define RB_PULLUP_KILL     7
`define CEX_RESERVED       3'h7
`define UART_TX_PIN        5'h04
`define UART_RX_PIN        5'h05
`endif

// [rtl/priority_pin_crossbar_config.v]
// pin configuration registers and priority crossbar for 24 port pins
//
// Notes on behaviour
// - input-kind bit one digital, zero analog
// - analog pin loses pullup, driver, receiver
// - all pins digital input after reset
// - drive-kind bit picks open-drain or push-pull
// - smbus pins always open-drain
// - pullup on open-drain pins unless killed
// - pullup off when driving zero or analog
// - route b bit 7 kills all pullups
// - route b bit 6 enables crossbar
// - crossbar off: inputs only, drivers off
// - route a bits 7..4 comparator outputs
// - route a bit 3 inverted system clock
// - route a bit 2 smbus data and clock
// - route a bit 1 spi, three or four
// - route a bit 0 uart on fixed pins
// - route b bits 5..3 timers, count input
// - route b bits 2..0 capture channel count
// - each signal but uart takes lowest free pin
// - bypass bit makes crossbar pass pin, except uart's fixed pins
// - leftover pins become general port pins
`timescale 1ns/1ps
`include "pin_xbar_consts.vh"

module priority_pin_crossbar_config #(
  parameter NPINS = 24
) (
  input  wire                    ref_clk,
  input  wire                    nrst,
  input  wire [`XBAR_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  input  wire                    spi_four_wire,
  input  wire                    uart_tx,
  output reg                     uart_rx,
  input  wire                    spi_sck_o,
  input  wire                    spi_sck_oe,
  output reg                     spi_sck_i,
  input  wire                    spi_miso_o,
  input  wire                    spi_miso_oe,
  output reg                     spi_miso_i,
  input  wire                    spi_mosi_o,
  input  wire                    spi_mosi_oe,
  output reg                     spi_mosi_i,
  output reg                     spi_nss_i,
  input  wire                    smbus_sda_o,
  output reg                     smbus_sda_i,
  input  wire                    smbus_scl_o,
  output reg                     smbus_scl_i,
  input  wire                    comparator0_out,
  input  wire                    comparator0_async_out,
  input  wire                    comparator1_out,
  input  wire                    comparator1_async_out,
  input  wire                    inverted_system_clock_out,
  input  wire [5:0]              capture_channel_o,
  input  wire [5:0]              capture_channel_oe,
  output reg  [5:0]              capture_channel_i,
  output reg                     array_ext_count_in,
  output reg                     timer0_in,
  output reg                     timer1_in,
  input  wire [NPINS-1:0]        pin_i,
  output reg  [NPINS-1:0]        pin_o,
  output reg  [NPINS-1:0]        pin_oe,
  output reg  [NPINS-1:0]        pin_pullup_on,
  output reg  [NPINS-1:0]        pin_receiver_on
);

////////////////////////////////////////////////////////////////////////////
// signal slots in priority order
localparam NSIG = 22;
localparam S_TX = 0, S_RX = 1, S_SCK = 2, S_MISO = 3, S_MOSI = 4;
localparam S_NSS = 5, S_SDA = 6, S_SCL = 7, S_CP0 = 8, S_CP0A = 9;
localparam S_CP1 = 10, S_CP1A = 11, S_CLK = 12, S_CEX = 13;
localparam S_ECI = 19, S_T0 = 20, S_T1 = 21;
// marker for a slot that got no pin, sized to match slot_pin
localparam [4:0] NO_PIN = NPINS[4:0];

reg [7:0]       route_a_ff;
reg [7:0]       route_b_ff;
reg [NPINS-1:0] input_kind_ff;
reg [NPINS-1:0] drive_kind_ff;
reg [NPINS-1:0] bypass_ff;
reg [NPINS-1:0] latch_ff;

////////////////////////////////////////////////////////////////////////////
// register bus
always @(posedge ref_clk) begin
  if (!nrst) begin
    route_a_ff    <= `RST_ROUTE;
    route_b_ff    <= `RST_ROUTE;
    input_kind_ff <= {3{`RST_INPUT_KIND}};
    drive_kind_ff <= {3{`RST_DRIVE_KIND}};
    bypass_ff     <= {3{`RST_BYPASS}};
    latch_ff      <= {3{`RST_LATCH}};
  end else if (reg_wr) begin
    case (reg_addr)
      `ADDR_ROUTE_A:     route_a_ff <= reg_wdata;
      `ADDR_ROUTE_B:     route_b_ff <= reg_wdata;
      `ADDR_INPUT_KIND0: input_kind_ff[7:0]   <= reg_wdata;
      `ADDR_INPUT_KIND1: input_kind_ff[15:8]  <= reg_wdata;
      `ADDR_INPUT_KIND2: input_kind_ff[23:16] <= reg_wdata;
      `ADDR_DRIVE_KIND0: drive_kind_ff[7:0]   <= reg_wdata;
      `ADDR_DRIVE_KIND1: drive_kind_ff[15:8]  <= reg_wdata;
      `ADDR_DRIVE_KIND2: drive_kind_ff[23:16] <= reg_wdata;
      `ADDR_BYPASS0:     bypass_ff[7:0]       <= reg_wdata;
      `ADDR_BYPASS1:     bypass_ff[15:8]      <= reg_wdata;
      `ADDR_BYPASS2:     bypass_ff[23:16]     <= reg_wdata;
      `ADDR_LATCH0:      latch_ff[7:0]        <= reg_wdata;
      `ADDR_LATCH1:      latch_ff[15:8]       <= reg_wdata;
      `ADDR_LATCH2:      latch_ff[23:16]      <= reg_wdata;
      default: begin
      end
    endcase
  end
end

// latch addresses read the pins; analog pins read zero
wire [NPINS-1:0] pin_rd = pin_i & input_kind_ff;

always @(posedge ref_clk) begin
  if (!nrst) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    case (reg_addr)
      `ADDR_ROUTE_A:     reg_rdata <= route_a_ff;
      `ADDR_ROUTE_B:     reg_rdata <= route_b_ff;
      `ADDR_INPUT_KIND0: reg_rdata <= input_kind_ff[7:0];
      `ADDR_INPUT_KIND1: reg_rdata <= input_kind_ff[15:8];
      `ADDR_INPUT_KIND2: reg_rdata <= input_kind_ff[23:16];
      `ADDR_DRIVE_KIND0: reg_rdata <= drive_kind_ff[7:0];
      `ADDR_DRIVE_KIND1: reg_rdata <= drive_kind_ff[15:8];
      `ADDR_DRIVE_KIND2: reg_rdata <= drive_kind_ff[23:16];
      `ADDR_BYPASS0:     reg_rdata <= bypass_ff[7:0];
      `ADDR_BYPASS1:     reg_rdata <= bypass_ff[15:8];
      `ADDR_BYPASS2:     reg_rdata <= bypass_ff[23:16];
      `ADDR_LATCH0:      reg_rdata <= pin_rd[7:0];
      `ADDR_LATCH1:      reg_rdata <= pin_rd[15:8];
      `ADDR_LATCH2:      reg_rdata <= pin_rd[23:16];
      default:           reg_rdata <= 8'h00;
    endcase
  end else begin
    reg_rdata <= 8'h00;
  end
end

////////////////////////////////////////////////////////////////////////////
// enabled signal slots
wire       crossbar_global_on = route_b_ff[`RB_XBAR_ON];
wire       pullup_kill        = route_b_ff[`RB_PULLUP_KILL];
wire [2:0] capture_channel_count = route_b_ff[`RB_CEX_HI:`RB_CEX_LO];

// route enables, one name per routing bit
wire uart_route                  = route_a_ff[`RA_UART];
wire spi_route                   = route_a_ff[`RA_SPI];
wire smbus_route                 = route_a_ff[`RA_SMBUS];
wire inverted_system_clock_route = route_a_ff[`RA_INVERTED_SYSTEM_CLOCK_OUT];
wire comparator0_route           = route_a_ff[`RA_CP0];
wire comparator0_async_route     = route_a_ff[`RA_CP0A];
wire comparator1_route           = route_a_ff[`RA_CP1];
wire comparator1_async_route     = route_a_ff[`RA_CP1A];
wire array_ext_count_route       = route_b_ff[`RB_ECI];
wire timer0_input_route          = route_b_ff[`RB_T0];
wire timer1_input_route          = route_b_ff[`RB_T1];

reg [NSIG-1:0] sig_en;
integer k;
always @* begin
  sig_en         = {NSIG{1'b0}};
  sig_en[S_TX]   = uart_route;
  sig_en[S_RX]   = uart_route;
  sig_en[S_SCK]  = spi_route;
  sig_en[S_MISO] = spi_route;
  sig_en[S_MOSI] = spi_route;
  sig_en[S_NSS]  = spi_route & spi_four_wire;
  sig_en[S_SDA]  = smbus_route;
  sig_en[S_SCL]  = smbus_route;
  sig_en[S_CP0]  = comparator0_route;
  sig_en[S_CP0A] = comparator0_async_route;
  sig_en[S_CP1]  = comparator1_route;
  sig_en[S_CP1A] = comparator1_async_route;
  sig_en[S_CLK]  = inverted_system_clock_route;
  // reserved count routes no channel
  for (k = 0; k < 6; k = k + 1)
    sig_en[S_CEX+k] = (capture_channel_count != `CEX_RESERVED) &&
                      (k < capture_channel_count);
  sig_en[S_ECI]  = array_ext_count_route;
  sig_en[S_T0]   = timer0_input_route;
  sig_en[S_T1]   = timer1_input_route;
end

////////////////////////////////////////////////////////////////////////////
// priority assignment: one pin index per slot, NPINS means none
// combinational chain; recomputed every cycle from registers and spi_four_wire
reg [NPINS-1:0] taken;
reg [4:0]       slot_pin [0:NSIG-1];
reg             found;
integer s, p;
always @* begin
  taken = bypass_ff;
  found = 1'b0;
  for (s = 0; s < NSIG; s = s + 1)
    slot_pin[s] = NO_PIN;
  if (sig_en[S_TX]) begin
    slot_pin[S_TX] = `UART_TX_PIN;
    slot_pin[S_RX] = `UART_RX_PIN;
    taken[`UART_TX_PIN] = 1'b1;
    taken[`UART_RX_PIN] = 1'b1;
  end
  for (s = S_SCK; s < NSIG; s = s + 1) begin
    found = 1'b0;
    for (p = 0; p < NPINS; p = p + 1) begin
      if (sig_en[s] && !found && !taken[p]) begin
        found       = 1'b1;
        slot_pin[s] = p[4:0];
        taken[p]    = 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// pin side: output, enable, pullup, receiver
// open-drain drives only its low level; push-pull drives both
function drive_en;
  input want;
  input level;
  input push_pull;
  begin
    drive_en = want & (~level | push_pull);
  end
endfunction

reg [NPINS-1:0] nxt_o;
reg [NPINS-1:0] nxt_oe;
reg [NPINS-1:0] open_drain;
integer q;
always @* begin
  nxt_o      = latch_ff;
  nxt_oe     = ~latch_ff | drive_kind_ff;
  open_drain = ~drive_kind_ff;
  for (q = 0; q < NSIG; q = q + 1) begin
    if (slot_pin[q] < NPINS) begin
      case (q)
        S_TX: begin
          nxt_o[slot_pin[q]]  = uart_tx;
          nxt_oe[slot_pin[q]] = drive_en(1'b1, uart_tx,
                                         drive_kind_ff[slot_pin[q]]);
        end
        S_SCK: begin
          nxt_o[slot_pin[q]]  = spi_sck_o;
          nxt_oe[slot_pin[q]] = drive_en(spi_sck_oe, spi_sck_o,
            drive_kind_ff[slot_pin[q]]);
        end
        S_MISO: begin
          nxt_o[slot_pin[q]]  = spi_miso_o;
          nxt_oe[slot_pin[q]] = drive_en(spi_miso_oe, spi_miso_o,
            drive_kind_ff[slot_pin[q]]);
        end
        S_MOSI: begin
          nxt_o[slot_pin[q]]  = spi_mosi_o;
          nxt_oe[slot_pin[q]] = drive_en(spi_mosi_oe, spi_mosi_o,
            drive_kind_ff[slot_pin[q]]);
        end
        S_SDA, S_SCL: begin
          nxt_o[slot_pin[q]]  = 1'b0;
          nxt_oe[slot_pin[q]] = (q == S_SDA) ? ~smbus_sda_o
                                             : ~smbus_scl_o;
          open_drain[slot_pin[q]] = 1'b1;
        end
        S_CP0, S_CP0A, S_CP1, S_CP1A, S_CLK: begin
          nxt_o[slot_pin[q]] = (q == S_CP0)  ? comparator0_out :
                               (q == S_CP0A) ? comparator0_async_out :
                               (q == S_CP1)  ? comparator1_out :
                               (q == S_CP1A) ? comparator1_async_out :
                                               inverted_system_clock_out;
          nxt_oe[slot_pin[q]] = drive_en(1'b1, nxt_o[slot_pin[q]],
                                         drive_kind_ff[slot_pin[q]]);
        end
        S_CEX, S_CEX+1, S_CEX+2, S_CEX+3, S_CEX+4, S_CEX+5: begin
          nxt_o[slot_pin[q]]  = capture_channel_o[q-S_CEX];
          nxt_oe[slot_pin[q]] = drive_en(capture_channel_oe[q-S_CEX],
            capture_channel_o[q-S_CEX], drive_kind_ff[slot_pin[q]]);
        end
        default: begin
          // inputs only: rx, nss, eci, t0, t1
          nxt_o[slot_pin[q]]  = 1'b1;
          nxt_oe[slot_pin[q]] = 1'b0;
        end
      endcase
    end
  end
  if (!crossbar_global_on)
    nxt_oe = {NPINS{1'b0}};
  nxt_oe = nxt_oe & input_kind_ff;
end

////////////////////////////////////////////////////////////////////////////
// per-pin pullup and receiver enables
wire [NPINS-1:0] nxt_receiver;
wire [NPINS-1:0] nxt_pullup;
wire [NPINS-1:0] pulls_low;
genvar g;
generate
  for (g = 0; g < NPINS; g = g + 1) begin : pin_cell
    // receiver off on analog pins saves power and noise
    assign nxt_receiver[g] = input_kind_ff[g];
    assign pulls_low[g]    = nxt_oe[g] & ~nxt_o[g];
    // pullup only on digital open-drain pins not pulling low
    assign nxt_pullup[g]   = ~pullup_kill & open_drain[g] &
                             input_kind_ff[g] & ~pulls_low[g];
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// peripheral inputs see idle high when not routed or crossbar off
function pick_in;
  input [4:0]       idx;
  input [NPINS-1:0] pins;
  begin
    pick_in = (idx < NPINS) ? pins[idx] : 1'b1;
  end
endfunction

wire [NPINS-1:0] rx_pins = crossbar_global_on ? pin_rd : {NPINS{1'b1}};
integer c;

always @(posedge ref_clk) begin
  if (!nrst) begin
    pin_o              <= {NPINS{1'b1}};
    pin_oe             <= {NPINS{1'b0}};
    pin_pullup_on      <= {NPINS{1'b1}};
    pin_receiver_on    <= {NPINS{1'b1}};
    uart_rx            <= 1'b1;
    spi_sck_i          <= 1'b1;
    spi_miso_i         <= 1'b1;
    spi_mosi_i         <= 1'b1;
    spi_nss_i          <= 1'b1;
    smbus_sda_i        <= 1'b1;
    smbus_scl_i        <= 1'b1;
    capture_channel_i  <= 6'h3F;
    array_ext_count_in <= 1'b1;
    timer0_in          <= 1'b1;
    timer1_in          <= 1'b1;
  end else begin
    pin_o           <= nxt_o;
    pin_oe          <= nxt_oe;
    pin_receiver_on <= nxt_receiver;
    pin_pullup_on   <= nxt_pullup;
    uart_rx         <= pick_in(slot_pin[S_RX], rx_pins);
    spi_sck_i       <= pick_in(slot_pin[S_SCK], rx_pins);
    spi_miso_i      <= pick_in(slot_pin[S_MISO], rx_pins);
    spi_mosi_i      <= pick_in(slot_pin[S_MOSI], rx_pins);
    spi_nss_i       <= pick_in(slot_pin[S_NSS], rx_pins);
    smbus_sda_i     <= pick_in(slot_pin[S_SDA], rx_pins);
    smbus_scl_i     <= pick_in(slot_pin[S_SCL], rx_pins);
    for (c = 0; c < 6; c = c + 1)
      capture_channel_i[c] <= pick_in(slot_pin[S_CEX+c], rx_pins);
    array_ext_count_in <= pick_in(slot_pin[S_ECI], rx_pins);
    timer0_in          <= pick_in(slot_pin[S_T0], rx_pins);
    timer1_in          <= pick_in(slot_pin[S_T1], rx_pins);
  end
end

endmodule

// [bench/pin_world.sv]
// pin-side model: outside drivers, weak pullups and floating pins
`timescale 1ns/1ps
module pin_world (
  input  wire        ref_clk,
  input  wire [23:0] pin_o,
  input  wire [23:0] pin_oe,
  input  wire [23:0] pin_pullup_on,
  input  wire [23:0] ext_en,
  input  wire [23:0] ext_lvl,
  output wire [23:0] pin_i
);
  reg [23:0] float_ff = 24'h555555;

  // an undriven, unpulled pin wanders so a stale level never passes
  always @(posedge ref_clk)
    float_ff <= ~float_ff;

  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl)
    | (~pin_oe & ~ext_en & (pin_pullup_on | float_ff));
endmodule

// [bench/pin_xbar_checker.sv]
// port-level assertions for the pin crossbar block
`timescale 1ns/1ps
`include "pin_xbar_consts.vh"
module pin_xbar_checker #(
  parameter NPINS = 24
) (
  input wire             ref_clk,
  input wire             nrst,
  input wire [7:0]       reg_addr,
  input wire [7:0]       reg_wdata,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [7:0]       reg_rdata,
  input wire             uart_tx,
  input wire             uart_rx,
  input wire             timer0_in,
  input wire [NPINS-1:0] pin_i,
  input wire [NPINS-1:0] pin_o,
  input wire [NPINS-1:0] pin_oe,
  input wire [NPINS-1:0] pin_pullup_on,
  input wire [NPINS-1:0] pin_receiver_on
);
  reg  [7:0] ra_ff, rb_ff, k0_ff, ra_p_ff, rb_p_ff, k0_p_ff;
  wire       on2;
  wire       off2;
  wire       uart2;

  // outputs lag config by one edge, so a setting counts once held twice
  assign on2   = rb_ff[6] & rb_p_ff[6];
  assign off2  = ~rb_ff[6] & ~rb_p_ff[6];
  assign uart2 = on2 & ra_ff[0] & ra_p_ff[0];

  always @(posedge ref_clk) begin
    if (!nrst) begin
      {ra_ff, rb_ff, k0_ff} <= {8'h00, 8'h00, 8'hFF};
      {ra_p_ff, rb_p_ff, k0_p_ff} <= {8'h00, 8'h00, 8'hFF};
    end else begin
      {ra_p_ff, rb_p_ff, k0_p_ff} <= {ra_ff, rb_ff, k0_ff};
      if (reg_wr && reg_addr == `ADDR_ROUTE_A)
        ra_ff <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_ROUTE_B)
        rb_ff <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_INPUT_KIND0)
        k0_ff <= reg_wdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_off_no_drive: assert property (off2 |-> pin_oe == '0)
    else $error("driver on while crossbar off");
  a_off_inputs_idle: assert property (off2 |-> uart_rx && timer0_in)
    else $error("peripheral input follows pin while crossbar off");
  a_analog_pin_quiet: assert property (
    (~k0_ff & ~k0_p_ff & (pin_oe[7:0] | pin_pullup_on[7:0]
      | pin_receiver_on[7:0])) == 8'h00)
    else $error("analog pin still has pullup, driver or receiver");
  a_low_no_pullup: assert property (
    (pin_pullup_on & pin_oe & ~pin_o) == '0)
    else $error("pullup on while pin drives low");
  a_kill_all_pullups: assert property (
    rb_ff[7] && rb_p_ff[7] |-> pin_pullup_on == '0)
    else $error("pullup on while pullups killed");
  a_read_route_a: assert property (
    reg_rd && reg_addr == `ADDR_ROUTE_A |=> reg_rdata == $past(ra_ff))
    else $error("route a read wrong");
  a_read_route_b: assert property (
    reg_rd && reg_addr == `ADDR_ROUTE_B |=> reg_rdata == $past(rb_ff))
    else $error("route b read wrong");
  a_uart_tx_pin: assert property (
    uart2 |-> (pin_oe[4] ? pin_o[4] : 1'b1) == $past(uart_tx))
    else $error("uart transmit not on its fixed pin");
  a_uart_rx_pin: assert property (
    uart2 |-> uart_rx == $past(pin_i[5]))
    else $error("uart receive not from its fixed pin");
endmodule

bind priority_pin_crossbar_config pin_xbar_checker #(.NPINS(NPINS)) chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .uart_tx(uart_tx), .uart_rx(uart_rx),
  .timer0_in(timer0_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
  .pin_pullup_on(pin_pullup_on), .pin_receiver_on(pin_receiver_on));

// [bench/tb_top.sv]
// self-checking bench for the pin crossbar block
`timescale 1ns/1ps
`include "pin_xbar_consts.vh"
module tb_top;
  reg         ref_clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         four_w = 1'b1;
  reg         tx = 1'b0;
  reg  [5:0]  spi_v = 6'h00;
  reg  [1:0]  smb_v = 2'h1;
  reg  [4:0]  src = 5'h00;
  reg  [5:0]  cex_o = 6'h00;
  reg  [23:0] ext_en = 24'hFFFFFF;
  reg  [23:0] ext_lvl = 24'h000000;
  wire [7:0]  rdata;
  wire [23:0] pin_i, pin_o, pin_oe, pin_pu, pin_rx;
  wire        u_rx, miso_i, nss_i, t0_in, sck_i, mosi_i, sda_i, scl_i;
  wire [5:0]  cex_i;
  integer     failures = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     b;

  always #2.5 ref_clk = ~ref_clk;

  priority_pin_crossbar_config #(.NPINS(24)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .spi_four_wire(four_w), .uart_tx(tx),
    .uart_rx(u_rx), .spi_sck_o(spi_v[0]), .spi_sck_oe(spi_v[1]),
    .spi_sck_i(sck_i), .spi_miso_o(spi_v[2]), .spi_miso_oe(spi_v[3]),
    .spi_miso_i(miso_i), .spi_mosi_o(spi_v[4]), .spi_mosi_oe(spi_v[5]),
    .spi_mosi_i(mosi_i), .spi_nss_i(nss_i), .smbus_sda_o(smb_v[0]),
    .smbus_sda_i(sda_i), .smbus_scl_o(smb_v[1]), .smbus_scl_i(scl_i),
    .comparator0_out(src[1]), .comparator0_async_out(src[2]),
    .comparator1_out(src[3]), .comparator1_async_out(src[4]),
    .inverted_system_clock_out(src[0]), .capture_channel_o(cex_o),
    .capture_channel_oe(6'h3F), .capture_channel_i(cex_i),
    .array_ext_count_in(), .timer0_in(t0_in), .timer1_in(),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pullup_on(pin_pu), .pin_receiver_on(pin_rx));

  pin_world world (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pullup_on(pin_pu), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .pin_i(pin_i));

  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      if (failures == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [23:0] exp, input [23:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [7:0] exp, input string nm);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, {16'h0000, exp}, {16'h0000, rdata});
    end
  endtask

  // pin outputs are registered; let changed config reach them
  task settle;
    begin
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    settle;
    chk("pin_oe", 24'h0, pin_oe);
    chk("receiver", 24'hFFFFFF, pin_rx);
    rd(`ADDR_ROUTE_A, 8'h00, "route_a");
    rd(`ADDR_ROUTE_B, 8'h00, "route_b");
    rd(`ADDR_INPUT_KIND0, 8'hFF, "input_kind0");
    rd(8'h00, 8'h00, "unmapped");
    wr(`ADDR_DRIVE_KIND0, 8'hFF);
    wr(`ADDR_ROUTE_A, 8'hF7);
    wr(`ADDR_ROUTE_B, 8'h10);
    settle;
    // routing chosen, crossbar still off, pins driven low outside
    chk("pin_oe", 24'h0, pin_oe);
    chk("timer0_in", 24'h1, {23'h0, t0_in});
    rd(`ADDR_ROUTE_A, 8'hF7, "route_a");
    wr(`ADDR_ROUTE_B, 8'h40);
    for (b = 3; b < 8; b = b + 1) begin
      wr(`ADDR_ROUTE_A, 8'h01 << b);
      src <= 5'h01 << (b - 3);
      settle;
      chk("pin0_high", 24'h1, pin_o & pin_oe & 24'h1);
      src <= ~(5'h01 << (b - 3));
      settle;
      chk("pin0_low", 24'h1, ~pin_o & pin_oe & 24'h1);
    end
    wr(`ADDR_ROUTE_A, 8'hF0);
    src <= 5'h0A;
    settle;
    chk("cmp_pins", 24'h5, pin_o & 24'hF);
    wr(`ADDR_BYPASS0, 8'h01);
    wr(`ADDR_ROUTE_A, 8'h07);
    spi_v <= 6'h23;
    settle;
    chk("drive_en", 24'h11A, pin_oe & 24'h19A);
    chk("drive_lvl", 24'h2, pin_o & 24'h11A);
    chk("scl_pullup", 24'h0, pin_pu & 24'h100);
    chk("spi_in", 24'h0, {22'h0, miso_i, nss_i});
    chk("spi_sck_mosi", 24'h2, {22'h0, sck_i, mosi_i});
    chk("smbus_in", 24'h0, {22'h0, sda_i, scl_i});
    chk("uart_rx", 24'h0, {23'h0, u_rx});
    four_w <= 1'b0;
    smb_v <= 2'h0;
    settle;
    chk("sda_pin6", 24'h40, pin_oe & 24'h40);
    chk("nss_idle", 24'h1, {23'h0, nss_i});
    wr(`ADDR_ROUTE_A, 8'h00);
    wr(`ADDR_BYPASS0, 8'h00);
    wr(`ADDR_DRIVE_KIND0, 8'h00);
    ext_lvl <= 24'h000001;
    cex_o <= 6'h02;
    wr(`ADDR_ROUTE_B, 8'h53);
    settle;
    chk("cex_drive", 24'h5, pin_oe & 24'h7);
    chk("timer0_in", 24'h0, {23'h0, t0_in});
    chk("cex_in", 24'h38, {18'h0, cex_i});
    wr(`ADDR_ROUTE_B, 8'h57);
    settle;
    chk("timer0_in", 24'h1, {23'h0, t0_in});
    wr(`ADDR_ROUTE_B, 8'h40);
    ext_en <= 24'h000000;
    wr(`ADDR_INPUT_KIND0, 8'hFE);
    wr(`ADDR_BYPASS0, 8'h01);
    settle;
    chk("pullup", 24'hFFFFFE, pin_pu);
    chk("receiver", 24'hFFFFFE, pin_rx);
    rd(`ADDR_LATCH0, 8'hFE, "port0_pins");
    wr(`ADDR_LATCH0, 8'hFD);
    wr(`ADDR_DRIVE_KIND0, 8'h04);
    settle;
    chk("pullup", 24'hFFFFF8, pin_pu);
    chk("pin_oe", 24'h6, pin_oe);
    wr(`ADDR_ROUTE_B, 8'hC0);
    settle;
    chk("pullup", 24'h0, pin_pu);
    print_verdict;
  end
endmodule
